// ==== core/sbc_pkg.sv ====
/*
  Constants shared by the serial command port: frame layout, register addresses,
  field positions inside control bytes, status register list and mode encodings.
  Assumes the chip's mode state machine and status sources live outside the port.
*/
package sbc_pkg;
  // Frame layout, first received bit is bit 0
  localparam int FRAME_BITS = 16;
  localparam int ADDR_MSB = 6;
  localparam int SEL_BIT = 7;
  localparam int DATA_LSB = 8;
  localparam logic [4:0] CNT_ADDR_DONE = 5'h07;
  localparam logic [4:0] CNT_FULL = 5'h10;
  localparam logic [4:0] CNT_MAX = 5'h1f;

  // Address ranges
  localparam logic [6:0] CTRL_LAST = 7'h1e;
  localparam logic [6:0] STAT_FIRST = 7'h40;

  // Control registers that the command checks look at
  localparam logic [6:0] ADDR_MODE_CTRL = 7'h01;
  localparam logic [6:0] ADDR_SUPPLY_CTRL = 7'h02;
  localparam logic [6:0] ADDR_WATCHDOG_CTRL = 7'h03;
  localparam logic [6:0] ADDR_BUS_CTRL_FIRST = 7'h04;
  localparam logic [6:0] ADDR_WAKE_CTRL_SECOND = 7'h07;
  localparam logic [6:0] ADDR_TIMER_CTRL = 7'h0c;

  // Field positions inside control bytes
  localparam int MODE_FLD_LSB = 6;
  localparam logic [1:0] MODE_REQ_NORMAL = 2'h0;
  localparam logic [1:0] MODE_REQ_SLEEP = 2'h1;
  localparam logic [1:0] MODE_REQ_STOP = 2'h2;
  localparam logic [1:0] MODE_REQ_SOFT_RESET = 2'h3;
  localparam int LOAD_SHARE_BIT = 2;
  localparam int WAKE_ONE_EN_BIT = 0;
  localparam int WAKE_TWO_EN_BIT = 1;
  localparam int WAKE_MEAS_BIT = 5;
  localparam logic [7:0] WAKE_EN_MASK = 8'h07;
  localparam int TIMER_PERIOD_LSB = 0;
  localparam int TIMER_ON_LSB = 3;

  // Status registers, index order used by the status array
  localparam int NSTAT = 9;
  localparam logic [6:0] STAT_ADDR [NSTAT] = '{7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h46, 7'h47, 7'h54, 7'h55};
  localparam int IDX_SUPPLY_SECOND = 0;
  localparam int IDX_SUPPLY_FIRST = 1;
  localparam int IDX_THERMAL = 2;
  localparam int IDX_DEVICE = 3;
  localparam int IDX_BUS_FAIL = 4;
  localparam int IDX_WAKE_FIRST = 5;
  localparam int IDX_WAKE_SECOND = 6;
  localparam int IDX_HS_OVERLOAD = 7;
  localparam int IDX_HS_OPEN_LOAD = 8;
  localparam int CMD_FAIL_BIT = 1;
  localparam logic [7:0] STAT_RESET = 8'h00;

  // Command stream buffer
  localparam int CMD_WIDTH = 15;
  localparam int CMD_DEPTH = 4;

  typedef enum logic [2:0] {
    SBC_MODE_INIT,
    SBC_MODE_NORMAL,
    SBC_MODE_STOP,
    SBC_MODE_SLEEP,
    SBC_MODE_RESTART
  } sbc_mode_e;
endpackage : sbc_pkg

// ==== core/sbc_spi_command_interface.sv ====
/*
  Serial command port of the power companion chip, plus its command FIFO.
  Assumes: serial clock, select and data in arrive asynchronously and are sampled
  by clk (200 MHz) well above the serial rate; chipMode, resetOutput and the status
  set strobes come from chip logic on clk.
*/
`timescale 1ns/1ps

module sbc_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  wire push = inValid & inReady;
  wire pop = outValid & outReady;

  // Honest flags straight from the occupancy count
  assign inReady = count != FULL;
  assign outValid = count != '0;
  assign outData = mem[rdPtr];

  // Storage words carry no reset; only the pointers define contents
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  // Pointers wrap at the last slot, so any depth works
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) wrPtr <= (wrPtr == LAST) ? '0 : wrPtr + 1'b1;
      if (pop) rdPtr <= (rdPtr == LAST) ? '0 : rdPtr + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end
endmodule : sbc_fifo

module sbc_spi_command_interface (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic serialClk,
  input wire logic select_n,
  input wire logic serialIn,
  output logic serialOut,
  output logic serialOutEn,
  input wire logic resetOutput,
  input sbc_pkg::sbc_mode_e chipMode,
  input wire logic [sbc_pkg::NSTAT*8-1:0] statusSet,
  output logic cmdValid,
  output logic [sbc_pkg::CMD_WIDTH-1:0] cmdWord,
  input wire logic cmdReady,
  output logic forceRestart,
  output logic forceNormal,
  output logic wakeInterrupt,
  output logic [7:0] statusSummary
);
  import sbc_pkg::*;

  // Status address to array index; used by the read path and the clear path
  function automatic logic [4:0] statIndex(input logic [6:0] addr);
    logic [4:0] idx;
    idx = 5'h1f;
    for (int i = 0; i < NSTAT; i++) begin
      if (STAT_ADDR[i] == addr) idx = 5'(i);
    end
    return idx;
  endfunction : statIndex

  // Two flops on data in and three on clock and select; edges are read from stages two and three only
  logic [2:0] clkSync;
  logic [2:0] selSync;
  logic [1:0] dinSync;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkSync <= 3'h0;
      selSync <= 3'h7;
      dinSync <= 2'h0;
    end else begin
      clkSync <= {clkSync[1:0], serialClk};
      selSync <= {selSync[1:0], select_n};
      dinSync <= {dinSync[0], serialIn};
    end
  end

  wire sclkHigh = clkSync[1];
  wire sclkRise = clkSync[1] & ~clkSync[2];
  wire sclkFall = ~clkSync[1] & clkSync[2];
  wire selFall = ~selSync[1] & selSync[2];
  wire selRise = selSync[1] & ~selSync[2];
  wire frameActive = ~selSync[1];
  wire serial_in = dinSync[1];

  logic [15:0] rxShift;
  logic [4:0] bitCount;
  logic [4:0] riseCount;
  logic clkHighSeen;
  logic resetSeen;
  logic errPending;
  logic [7:0] summaryLatch;
  logic [7:0] dataLatch;
  logic dataLoaded;
  logic pendingValid;
  logic [15:0] pendingWord;
  logic [7:0] ctrlMem [32];
  logic [7:0] statReg [NSTAT];

  // Receive path: one bit per falling edge, count saturates so long frames stay wrong
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxShift <= 16'h0000;
      bitCount <= 5'h00;
    end else if (selFall) begin
      bitCount <= 5'h00;
    end else if (frameActive && sclkFall) begin
      rxShift <= {serial_in, rxShift[15:1]};
      bitCount <= (bitCount == CNT_MAX) ? CNT_MAX : bitCount + 5'h01;
    end
  end

  // Frame faults collected while select is low
  wire clkHighAtEdge = (selFall | selRise) & sclkHigh;
  wire badCount = (bitCount != 5'h00) && (bitCount != CNT_FULL);
  wire frameFault = badCount | clkHighSeen | resetSeen;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clkHighSeen <= 1'b0;
      resetSeen <= 1'b0;
    end else begin
      clkHighSeen <= (selFall ? 1'b0 : clkHighSeen) | clkHighAtEdge;
      resetSeen <= (selFall ? 1'b0 : resetSeen) | (frameActive & ~resetOutput);
    end
  end

  // Error flag: raised at frame end, shown at the next frame start, then consumed
  wire errRaise = selRise & (frameFault | clkHighAtEdge | (pendingValid & (bitCount == CNT_FULL)));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      errPending <= 1'b0;
    end else begin
      errPending <= (selFall ? 1'b0 : errPending) | errRaise | (selFall & sclkHigh);
    end
  end

  // Command captured only from clean 16-clock frames outside restart mode
  wire captureOk = selRise && !frameFault && !clkHighAtEdge && (bitCount == CNT_FULL)
                   && (chipMode != SBC_MODE_RESTART) && !pendingValid;
  wire [6:0] rxAddr = rxShift[15:9];

  // Read path for the answer byte; controls and status show content before this frame
  wire [4:0] rdIdx = statIndex(rxAddr);
  wire [7:0] readByte = (rxAddr <= CTRL_LAST) ? ctrlMem[rxAddr[4:0]] :
                        (rdIdx < 5'(NSTAT)) ? statReg[rdIdx[3:0]] : 8'h00;

  // Summary byte, one bit per status register except the two wake registers, which share bit 4; wake level is not part of it
  assign statusSummary = {|statReg[IDX_HS_OPEN_LOAD], |statReg[IDX_HS_OVERLOAD], |statReg[IDX_SUPPLY_SECOND],
                          |statReg[IDX_WAKE_FIRST] | (|statReg[IDX_WAKE_SECOND]), |statReg[IDX_BUS_FAIL],
                          |statReg[IDX_DEVICE], |statReg[IDX_THERMAL], |statReg[IDX_SUPPLY_FIRST]};

  // Answer word: summary in the low byte, addressed data in the high byte
  wire [15:0] answerWord = {dataLatch, summaryLatch};
  wire [4:0] nextRise = (riseCount == CNT_MAX) ? CNT_MAX : riseCount + 5'h01;
  wire nextBit = (riseCount < CNT_FULL) ? answerWord[riseCount[3:0]] : 1'b0;

  // Transmit path; the error bit sits on the line before the first rising edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      serialOut <= 1'b1;
      riseCount <= 5'h00;
      summaryLatch <= 8'h00;
      dataLatch <= 8'h00;
      dataLoaded <= 1'b0;
    end else begin
      if (selFall) begin
        riseCount <= 5'h00;
        summaryLatch <= statusSummary;
        dataLoaded <= 1'b0;
        dataLatch <= 8'h00;
      end else if (frameActive && sclkRise) begin
        riseCount <= nextRise;
      end else if (frameActive && !dataLoaded && bitCount == CNT_ADDR_DONE) begin
        dataLatch <= readByte;
        dataLoaded <= 1'b1;
      end
      if (!resetOutput) serialOut <= 1'b1;
      else if (selFall) serialOut <= errPending;
      else if (frameActive && sclkRise) serialOut <= nextBit;
    end
  end

  // Line released once select returns high
  assign serialOutEn = frameActive;

  // Decode of the held command
  wire [6:0] pAddr = pendingWord[ADDR_MSB:0];
  wire pSel = pendingWord[SEL_BIT];
  wire [7:0] pData = pendingWord[15:DATA_LSB];
  wire [1:0] modeReq = pData[MODE_FLD_LSB +: 2];
  wire [7:0] wakeCtrl = ctrlMem[ADDR_WAKE_CTRL_SECOND[4:0]];
  wire [7:0] supplyCtrl = ctrlMem[ADDR_SUPPLY_CTRL[4:0]];
  wire stuck = (pendingWord == 16'h0000) || (pendingWord == 16'hffff);
  wire isWrite = (pAddr <= CTRL_LAST) && pSel && !stuck;
  wire [4:0] clrIdx = statIndex(pAddr);
  wire isClear = (pAddr >= STAT_FIRST) && pSel && !stuck && (clrIdx < 5'(NSTAT));
  wire wMode = isWrite && pAddr == ADDR_MODE_CTRL;
  wire wWatchdog = isWrite && pAddr == ADDR_WATCHDOG_CTRL;
  wire wTimer = isWrite && pAddr == ADDR_TIMER_CTRL;
  wire wSupply = isWrite && pAddr == ADDR_SUPPLY_CTRL;
  wire inStop = chipMode == SBC_MODE_STOP;
  wire inInit = chipMode == SBC_MODE_INIT;
  wire reqSleep = wMode && modeReq == MODE_REQ_SLEEP;
  wire reqStop = wMode && modeReq == MODE_REQ_STOP;
  wire stopAllowed = wWatchdog || (wMode && (modeReq == MODE_REQ_NORMAL || modeReq == MODE_REQ_SOFT_RESET));
  wire stopBlocked = inStop && isWrite && !stopAllowed;
  wire stopToSleep = inStop && reqSleep;
  wire initLowPower = inInit && (reqSleep || reqStop);
  wire busWakeNone = ctrlMem[ADDR_BUS_CTRL_FIRST[4:0]] == 8'h00;
  wire noWakeSource = reqSleep && !inStop && !inInit && busWakeNone && wakeCtrl == 8'h00;
  wire onlyWakeOneTwo = ((wakeCtrl & WAKE_EN_MASK) != 8'h00) && !wakeCtrl[2]
                        && (wakeCtrl[WAKE_ONE_EN_BIT] | wakeCtrl[WAKE_TWO_EN_BIT]);
  wire measOnly = reqSleep && !inStop && !inInit && wakeCtrl[WAKE_MEAS_BIT] && onlyWakeOneTwo
                  && busWakeNone;
  wire wdParityBad = wWatchdog && ^pData;
  wire timerBad = wTimer && (pData[TIMER_ON_LSB +: 3] >= pData[TIMER_PERIOD_LSB +: 3]);
  wire loadShareClr = wSupply && !inStop && supplyCtrl[LOAD_SHARE_BIT] && !pData[LOAD_SHARE_BIT];
  wire wakePending = (statReg[IDX_WAKE_FIRST] != 8'h00) || (statReg[IDX_WAKE_SECOND] != 8'h00);
  wire stopWithWake = reqStop && !inInit && !inStop && wakePending;
  wire dropWrite = stuck | stopBlocked | initLowPower | wdParityBad | timerBad;
  wire failSet = dropWrite | noWakeSource | measOnly | loadShareClr;
  wire doWrite = isWrite && !dropWrite;
  wire [7:0] storeData = loadShareClr ? (pData | (8'h01 << LOAD_SHARE_BIT)) : pData;

  // A write waits for room in the command FIFO; reads and clears never wait
  logic fifoInReady;
  wire fire = pendingValid && (fifoInReady || !doWrite);

  // Held command; a clean frame arriving while one still waits is flagged as an error
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pendingValid <= 1'b0;
      pendingWord <= 16'h0000;
    end else if (captureOk) begin
      pendingValid <= 1'b1;
      pendingWord <= rxShift;
    end else if (fire) begin
      pendingValid <= 1'b0;
    end
  end

  // Local copy of control bytes, updated only after select high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++) ctrlMem[i] <= 8'h00;
    end else if (fire && doWrite) begin
      ctrlMem[pAddr[4:0]] <= storeData;
    end
  end

  // Status bytes: chip events set bits, read-and-clear empties; a new event beats the clear
  genvar gi;
  generate
    for (gi = 0; gi < NSTAT; gi++) begin : gStat
      wire clrThis = fire && isClear && clrIdx == 5'(gi);
      wire [7:0] failBit = (gi == IDX_DEVICE && fire && failSet) ? (8'h01 << CMD_FAIL_BIT) : 8'h00;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) statReg[gi] <= STAT_RESET;
        else statReg[gi] <= (clrThis ? 8'h00 : statReg[gi]) | statusSet[gi*8 +: 8] | failBit;
      end
    end
  endgenerate

  // Mode side effects as one-cycle strobes to the mode logic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      forceRestart <= 1'b0;
      forceNormal <= 1'b0;
      wakeInterrupt <= 1'b0;
    end else begin
      forceRestart <= fire & (stopToSleep | noWakeSource | measOnly);
      forceNormal <= fire & initLowPower;
      wakeInterrupt <= fire & stopWithWake;
    end
  end

  sbc_fifo #(
    .WIDTH(CMD_WIDTH),
    .DEPTH(CMD_DEPTH)
  ) cmdFifo (
    .clk(clk),
    .rst_n(rst_n),
    .inValid(fire & doWrite),
    .inData({pAddr, storeData}),
    .inReady(fifoInReady),
    .outValid(cmdValid),
    .outData(cmdWord),
    .outReady(cmdReady)
  );

  // Checks on the port's own behaviour
  sequence seqCleanEnd;
    selRise && bitCount == CNT_FULL && !frameFault && !clkHighAtEdge;
  endsequence

  AST_RELEASE: assert property (@(posedge clk) disable iff (!rst_n) selRise |=> !serialOutEn)
    else $error("serial output still driven after select release");
  AST_RESET_HIGH: assert property (@(posedge clk) disable iff (!rst_n) !resetOutput |=> serialOut)
    else $error("serial output not high while reset output low");
  AST_BAD_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
      selRise && badCount && !pendingValid |=> errPending && !pendingValid)
    else $error("wrong clock count not discarded");
  AST_ERR_LEADS: assert property (@(posedge clk) disable iff (!rst_n)
      selFall && resetOutput |=> serialOut == $past(errPending) ##1 (serialOut == $past(serialOut) || $past(sclkRise)))
    else $error("error bit not shown at frame start");
  AST_FAIL_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
      fire && failSet |=> statReg[IDX_DEVICE][CMD_FAIL_BIT])
    else $error("command failure flag not set");
  AST_STOP_SLEEP: assert property (@(posedge clk) disable iff (!rst_n)
      fire && stopToSleep |=> forceRestart && !forceNormal ##1 !forceRestart)
    else $error("stop to sleep did not force one restart strobe");
  AST_INIT_LOWPOWER: assert property (@(posedge clk) disable iff (!rst_n)
      fire && initLowPower |-> !doWrite ##1 forceNormal)
    else $error("init low power request not turned to normal");
  AST_LOAD_SHARE: assert property (@(posedge clk) disable iff (!rst_n)
      fire && loadShareClr |=> ctrlMem[ADDR_SUPPLY_CTRL[4:0]][LOAD_SHARE_BIT])
    else $error("load sharing bit was cleared");
  AST_RESTART_MUTE: assert property (@(posedge clk) disable iff (!rst_n)
      selRise && chipMode == SBC_MODE_RESTART && !pendingValid |=> !pendingValid)
    else $error("command taken during restart mode");
  AST_CAPTURE: assert property (@(posedge clk) disable iff (!rst_n)
      seqCleanEnd ##0 (chipMode != SBC_MODE_RESTART && !pendingValid) |=> pendingValid && pendingWord == $past(rxShift))
    else $error("clean frame not captured");
  AST_SUMMARY: assert property (@(posedge clk) disable iff (!rst_n)
      statusSet[IDX_WAKE_FIRST*8 +: 8] != 8'h00 |=> statusSummary[4] && statReg[IDX_WAKE_FIRST] != 8'h00)
    else $error("summary byte misses a wake status event");
  AST_STUCK: assert property (@(posedge clk) disable iff (!rst_n) fire && stuck |-> failSet && !doWrite)
    else $error("stuck frame accepted");
endmodule : sbc_spi_command_interface

// ==== sim/sbc_host_model.sv ====
/*
  Host side of the serial command link: drives select, serial clock and data in.
  Assumes clk is the 200 MHz system clock and the bench calls runFrame.
*/
`timescale 1ns/1ps
module sbc_host_model (
  input wire logic clk,
  output logic select_n,
  output logic serialClk,
  output logic serialIn,
  input wire logic serialOut
);
  localparam int HALF = 8; // 40 ns, half of the 80 ns link period

  // Idle link: clock low so select edges never see it high
  initial begin
    select_n = 1'b1;
    serialClk = 1'b0;
    serialIn = 1'b0;
  end

  // One frame, LSB first; nClk of 0 sends select alone, any count other than 0 or 16 gives a malformed frame
  task automatic runFrame(input logic [15:0] word, input int nClk, output logic errBit, output logic [15:0] answer);
    answer = 16'h0000;
    @(negedge clk);
    select_n = 1'b0;
    repeat (HALF) @(negedge clk);
    errBit = serialOut;
    for (int i = 0; i < nClk; i++) begin
      serialIn = word[i % 16];
      serialClk = 1'b1;
      repeat (HALF) @(negedge clk);
      answer[i % 16] = serialOut;
      serialClk = 1'b0;
      repeat (HALF) @(negedge clk);
    end
    select_n = 1'b1;
    serialIn = ~serialIn; // Released data line must not hold its last value
    repeat (12) @(negedge clk);
  endtask : runFrame
endmodule : sbc_host_model

// ==== sim/tb_top.sv ====
/*
  Bench of the serial command port: host model on the link, chip side driven here.
  Assumes the host model frame timing and the port's two- and three-flop synchronisers.
*/
`timescale 1ns/1ps
module tb_top;
  import sbc_pkg::*;
  logic clk = 1'b0;
  logic rst_n, resetOutput, cmdReady, select_n, serialClk, serialIn, serialOut, serialOutEn;
  logic cmdValid, forceRestart, forceNormal, wakeInterrupt, errBit;
  sbc_mode_e chipMode;
  logic [NSTAT*8-1:0] statusSet;
  logic [CMD_WIDTH-1:0] cmdWord, lastCmd;
  logic [7:0] statusSummary;
  logic [15:0] answer;
  int errors = 0, checks = 0, nRestart = 0, nNormal = 0, nWake = 0, nCmd = 0;
  // Released line shows the inverse, so a sample taken outside the driven window stands out
  wire sdoLine = serialOutEn ? serialOut : ~serialOut;

  always #2.5 clk = ~clk;

  sbc_spi_command_interface uut (.clk(clk), .rst_n(rst_n), .serialClk(serialClk), .select_n(select_n),
    .serialIn(serialIn), .serialOut(serialOut), .serialOutEn(serialOutEn), .resetOutput(resetOutput),
    .chipMode(chipMode), .statusSet(statusSet), .cmdValid(cmdValid), .cmdWord(cmdWord), .cmdReady(cmdReady),
    .forceRestart(forceRestart), .forceNormal(forceNormal), .wakeInterrupt(wakeInterrupt),
    .statusSummary(statusSummary));
  sbc_host_model host (.clk(clk), .select_n(select_n), .serialClk(serialClk), .serialIn(serialIn),
    .serialOut(sdoLine));

  // Pulses last one cycle, so they are tallied rather than polled
  always @(posedge clk) begin
    if (forceRestart === 1'b1) nRestart++;
    if (forceNormal === 1'b1) nNormal++;
    if (wakeInterrupt === 1'b1) nWake++;
    if (cmdValid === 1'b1 && cmdReady === 1'b1) begin
      nCmd++;
      lastCmd = cmdWord;
    end
  end

  task automatic chkv(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chkv

  task automatic xfer(input logic [6:0] a, input logic s, input logic [7:0] d);
    host.runFrame({d, s, a}, 16, errBit, answer);
  endtask : xfer

  // Reads and clears the device status byte, checking the failure bit both ways
  task automatic failIs(input logic e);
    chkv("summary fail", 16'(e), 16'(statusSummary[2]));
    xfer(7'h43, 1'b1, 8'h00);
    chkv("fail flag", 16'(e), 16'(answer[9]));
    chkv("answer summary", 16'(e), 16'(answer[2]));
  endtask : failIs

  task automatic setMode(input sbc_mode_e m);
    @(negedge clk);
    chipMode = m;
  endtask : setMode

  task automatic t_sleep;
    xfer(7'h01, 1'b1, 8'h40);
    chkv("restart", 16'd1, 16'(nRestart));
    failIs(1'b1);
    xfer(7'h07, 1'b1, 8'h21);
    xfer(7'h01, 1'b1, 8'h40);
    chkv("restart", 16'd2, 16'(nRestart));
    failIs(1'b1);
    xfer(7'h07, 1'b1, 8'h01);
    xfer(7'h01, 1'b1, 8'h40);
    chkv("restart", 16'd2, 16'(nRestart));
    failIs(1'b0);
  endtask : t_sleep

  task automatic t_write;
    int c0;
    c0 = nCmd;
    xfer(7'h04, 1'b1, 8'h5a);
    chkv("old byte", 16'h0000, 16'(answer[15:8]));
    chkv("cmd word", 16'h045a, 16'(lastCmd));
    xfer(7'h04, 1'b0, 8'h00);
    chkv("read byte", 16'h005a, 16'(answer[15:8]));
    chkv("cmd count", 16'(c0 + 1), 16'(nCmd));
  endtask : t_write

  task automatic t_stop;
    int c0;
    setMode(SBC_MODE_STOP);
    c0 = nCmd;
    xfer(7'h01, 1'b1, 8'h40);
    chkv("restart", 16'd3, 16'(nRestart));
    failIs(1'b1);
    xfer(7'h0c, 1'b1, 8'h0f);
    failIs(1'b1);
    xfer(7'h03, 1'b1, 8'h03);
    xfer(7'h01, 1'b1, 8'h00);
    xfer(7'h01, 1'b1, 8'hc0);
    failIs(1'b0);
    setMode(SBC_MODE_INIT);
    xfer(7'h01, 1'b1, 8'h80);
    failIs(1'b1);
    xfer(7'h01, 1'b1, 8'h40);
    failIs(1'b1);
    chkv("normal", 16'd2, 16'(nNormal));
    setMode(SBC_MODE_RESTART);
    xfer(7'h0c, 1'b1, 8'h0f);
    failIs(1'b0);
    chkv("cmd count", 16'(c0 + 3), 16'(nCmd));
    setMode(SBC_MODE_NORMAL);
  endtask : t_stop

  task automatic t_checks;
    int c0;
    c0 = nCmd;
    xfer(7'h03, 1'b1, 8'h01);
    failIs(1'b1);
    xfer(7'h0c, 1'b1, 8'h12);
    failIs(1'b1);
    host.runFrame(16'h0000, 16, errBit, answer);
    failIs(1'b1);
    host.runFrame(16'hffff, 16, errBit, answer);
    failIs(1'b1);
    chkv("cmd count", 16'(c0), 16'(nCmd));
    xfer(7'h02, 1'b1, 8'h04);
    xfer(7'h02, 1'b1, 8'h00);
    failIs(1'b1);
    xfer(7'h02, 1'b0, 8'h00);
    chkv("load share", 16'h0004, 16'(answer[15:8]));
  endtask : t_checks

  task automatic t_wake;
    @(negedge clk);
    statusSet[IDX_WAKE_FIRST*8] = 1'b1;
    @(negedge clk);
    statusSet = '0;
    @(negedge clk);
    chkv("wake summary", 16'h0001, 16'(statusSummary[4]));
    xfer(7'h01, 1'b1, 8'h80);
    chkv("wake int", 16'd1, 16'(nWake));
    failIs(1'b0);
    xfer(7'h46, 1'b1, 8'h00);
    chkv("wake byte", 16'h0001, 16'(answer[15:8]));
    chkv("wake summary", 16'h0000, 16'(statusSummary[4]));
  endtask : t_wake

  task automatic t_frame;
    int c0;
    c0 = nCmd;
    host.runFrame(16'h0f8c, 8, errBit, answer);
    host.runFrame(16'h0000, 0, errBit, answer);
    chkv("err short", 16'h0001, 16'(errBit));
    host.runFrame(16'h0000, 0, errBit, answer);
    chkv("err clear", 16'h0000, 16'(errBit));
    @(negedge clk);
    resetOutput = 1'b0;
    xfer(7'h0c, 1'b1, 8'h0f);
    chkv("out in reset", 16'hffff, answer);
    resetOutput = 1'b1;
    host.runFrame(16'h0000, 0, errBit, answer);
    chkv("err reset", 16'h0001, 16'(errBit));
    chkv("cmd count", 16'(c0), 16'(nCmd));
  endtask : t_frame

  task automatic t_fifo;
    int c0;
    c0 = nCmd;
    cmdReady = 1'b0;
    for (int i = 0; i < 6; i++) xfer(7'h0c, 1'b1, 8'h07 + 8'(8 * i));
    host.runFrame(16'h0000, 0, errBit, answer);
    chkv("err full", 16'h0001, 16'(errBit));
    cmdReady = 1'b1;
    repeat (20) @(negedge clk);
    chkv("drained", 16'(c0 + 5), 16'(nCmd));
    chkv("last word", 16'h0c27, 16'(lastCmd));
  endtask : t_fifo

  task automatic final_report;
    if (errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  // About fifty frames of some 280 clocks each are expected; allow roughly three times that
  initial begin
    #200000;
    errors++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    resetOutput = 1'b1;
    cmdReady = 1'b1;
    chipMode = SBC_MODE_NORMAL;
    statusSet = '0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chkv("released", 16'h0000, {7'h00, serialOutEn, statusSummary});
    t_sleep();
    t_write();
    t_stop();
    t_checks();
    t_wake();
    t_frame();
    t_fifo();
    final_report();
  end
endmodule : tb_top
